// ### tbp_pkg.sv
// Constants shared by the transmit command parser and the host writer.
// Assumes a single clock domain and a 32-bit word stream between the two ends.
// How it works
// - End alignment codes: 4, 16, 32 bytes, reserved.
// - Start offset sits in bits 20:16.
// - Bit 13 of word A marks first buffer.
// - Bit 12 of word A marks last buffer.
// - Bits 10:0 of word A give payload bytes.
// - Sum of buffer sizes must equal packet length.
// - Padding words after payload are discarded.
// - Tag in word B goes to status.
// - Word B bit 13 disables CRC append.
// - Word B bit 12 disables padding, forces CRC.
// - Word B bits 10:0 are packet length.
// - Data follows both command words in order.
// - Low offset bits select first byte lane.
// - Upper offset bits skip whole leading words.
// - Unused trailing bytes are not forwarded.
// - Host pads each buffer to end alignment.
// - Host keeps middle buffers at least four bytes.
// - Any start, end and edge-buffer length accepted.
// - Host writes zero to reserved bits; the host end passes word A bits 23:21 through.
// - Word B identical across buffers, else error.
// - Word A bit 31 requests loaded flag.
// - Host sends both command words per buffer.
package tbp_pkg;
   localparam int        IOC_BIT      = 31;
   localparam int        ALIGN_HI     = 25;
   localparam int        ALIGN_LO     = 24;
   localparam int        OFS_HI       = 20;
   localparam int        OFS_LO       = 16;
   localparam int        FIRST_BIT    = 13;
   localparam int        LAST_BIT     = 12;
   localparam int        SIZE_HI      = 10;
   localparam int        TAG_HI       = 31;
   localparam int        TAG_LO       = 16;
   localparam int        NOCRC_BIT    = 13;
   localparam int        NOPAD_BIT    = 12;
   localparam logic [1:0] ALIGN_4     = 2'h0;
   localparam logic [1:0] ALIGN_16    = 2'h1;
   localparam logic [1:0] ALIGN_32    = 2'h2;
   localparam logic [31:0] RSVD_A_MASK = 32'h7C00C800;
   localparam logic [31:0] RSVD_B_MASK = 32'h0000C800;
   // Host command, data and status register offsets on APB.
   localparam logic [7:0] OFS_CMD_A   = 8'h00;
   localparam logic [7:0] OFS_CMD_B   = 8'h04;
   localparam logic [7:0] OFS_DATA    = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0C;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
endpackage

// ### tbp_if.sv
// Word stream from host writer to command parser, and flags back.
// Assumes both ends share clock; the bench joins the modports.
`timescale 1ns/10ps
`default_nettype none
interface tbp_if;
   logic [31:0] word;
   logic        word_valid;
   logic        word_ready;
   logic        tx_error;
   logic        loaded;
   modport device (input word, input word_valid, output word_ready,
                   output tx_error, output loaded);
   modport host   (output word, output word_valid, input word_ready,
                   input tx_error, input loaded);
endinterface
`default_nettype wire

// ### tbp_parser.sv
// Transmit command parser: decodes words A and B, strips offsets and padding,
// forwards payload bytes to the MAC side and checks lengths.
// Assumes the host end follows the word order: A, B, then the buffer words.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module tbp_parser (
   input  wire logic         clock,
   input  wire logic         reset,
   tbp_if.device             link,
   output var  logic [7:0]   mac_byte_ff,
   output var  logic         mac_valid_ff,
   output var  logic         mac_sof_ff,
   output var  logic         mac_eof_ff,
   output var  logic [15:0]  status_tag_ff,
   output var  logic         status_no_crc_ff,
   output var  logic         status_no_pad_ff,
   output var  logic         status_valid_ff,
   output var  logic         transmit_error_flag_ff,
   output var  logic         buffer_loaded_flag_ff
);
   import tbp_pkg::*;
   typedef enum logic [1:0] {TBP_CMD_A, TBP_CMD_B, TBP_DATA, TBP_BYTES} tbp_state_e;
   tbp_state_e  state_ff;
   logic [31:0] cmd_a_ff;
   logic [31:0] cmd_b_ff;
   logic [31:0] pkt_b_ff;
   logic        in_pkt_ff;
   logic [11:0] sum_ff;
   logic [10:0] left_ff;
   logic [9:0]  words_ff;
   logic [2:0]  skip_ff;
   logic [31:0] hold_ff;
   logic [1:0]  lane_ff;
   logic        first_byte_ff;
   logic        take;
   logic        buf_end;
   logic [5:0]  span;
   logic [9:0]  total_words;
   logic [9:0]  align_words;
   logic [11:0] new_sum;
   logic        err_now;

   assign link.word_ready = (state_ff != TBP_BYTES);
   assign take = link.word_valid && link.word_ready;
   assign link.tx_error = transmit_error_flag_ff;
   assign link.loaded = buffer_loaded_flag_ff;

   // Words spanned by offset plus payload, rounded up to the end alignment.
   always_comb begin
      span = {1'b0, link.word[OFS_HI:OFS_LO]};
      total_words = 10'((12'(span) + 12'(link.word[SIZE_HI:0]) + 12'h3) >> 2);
      case (link.word[ALIGN_HI:ALIGN_LO])
         ALIGN_16: align_words = (total_words + 10'h3) & 10'h3FC;
         ALIGN_32: align_words = (total_words + 10'h7) & 10'h3F8;
         default:  align_words = total_words;
      endcase
   end

   assign buf_end = (state_ff == TBP_BYTES) && (left_ff == 11'h1) && (lane_ff == 2'h3 ||
                    left_ff == 11'h1);
   assign new_sum = sum_ff + 12'(cmd_a_ff[SIZE_HI:0]);
   assign err_now = cmd_a_ff[LAST_BIT] && (new_sum != {1'b0, pkt_b_ff[SIZE_HI:0]});

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_ff <= TBP_CMD_A;
         cmd_a_ff <= RESET_WORD;
         cmd_b_ff <= RESET_WORD;
         words_ff <= 10'h0;
         skip_ff <= 3'h0;
         hold_ff <= RESET_WORD;
         lane_ff <= 2'h0;
         left_ff <= 11'h0;
      end else begin
         case (state_ff)
            TBP_CMD_A: if (take) begin
               cmd_a_ff <= link.word;
               words_ff <= align_words;
               skip_ff <= link.word[OFS_HI:OFS_LO+2];
               lane_ff <= link.word[OFS_LO+1:OFS_LO];
               left_ff <= link.word[SIZE_HI:0];
               state_ff <= TBP_CMD_B;
            end
            TBP_CMD_B: if (take) begin
               cmd_b_ff <= link.word;
               state_ff <= (words_ff == 10'h0) ? TBP_CMD_A : TBP_DATA;
            end
            TBP_DATA: if (take) begin
               words_ff <= words_ff - 10'h1;
               if (skip_ff != 3'h0) begin
                  skip_ff <= skip_ff - 3'h1;
               end else if (left_ff != 11'h0) begin
                  hold_ff <= link.word;
                  state_ff <= TBP_BYTES;
               end else if (words_ff == 10'h1) begin
                  state_ff <= TBP_CMD_A;
               end
            end
            TBP_BYTES: begin
               left_ff <= left_ff - 11'h1;
               lane_ff <= lane_ff + 2'h1;
               if (left_ff == 11'h1) begin
                  // Remaining lanes of this word are never forwarded.
                  lane_ff <= 2'h0;
                  state_ff <= (words_ff == 10'h0) ? TBP_CMD_A : TBP_DATA;
               end else if (lane_ff == 2'h3) begin
                  state_ff <= TBP_DATA;
               end
            end
            default: state_ff <= TBP_CMD_A;
         endcase
      end
   end

   // Byte output toward the MAC side, one byte per cycle.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mac_byte_ff <= 8'h00;
         mac_valid_ff <= 1'b0;
         mac_sof_ff <= 1'b0;
         mac_eof_ff <= 1'b0;
         first_byte_ff <= 1'b0;
      end else begin
         mac_valid_ff <= (state_ff == TBP_BYTES);
         mac_byte_ff <= hold_ff[8*lane_ff +: 8];
         mac_sof_ff <= (state_ff == TBP_BYTES) && first_byte_ff;
         mac_eof_ff <= buf_end && cmd_a_ff[LAST_BIT];
         if (state_ff == TBP_CMD_B && take) begin
            first_byte_ff <= cmd_a_ff[FIRST_BIT];
         end else if (state_ff == TBP_BYTES) begin
            first_byte_ff <= 1'b0;
         end
      end
   end

   // Packet accounting, word B consistency and status.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pkt_b_ff <= RESET_WORD;
         in_pkt_ff <= 1'b0;
         sum_ff <= 12'h0;
         transmit_error_flag_ff <= 1'b0;
         buffer_loaded_flag_ff <= 1'b0;
         status_tag_ff <= 16'h0000;
         status_no_crc_ff <= 1'b0;
         status_no_pad_ff <= 1'b0;
         status_valid_ff <= 1'b0;
      end else begin
         status_valid_ff <= 1'b0;
         buffer_loaded_flag_ff <= 1'b0;
         if (state_ff == TBP_CMD_B && take) begin
            if (cmd_a_ff[FIRST_BIT]) begin
               pkt_b_ff <= link.word;
               sum_ff <= 12'h0;
               in_pkt_ff <= 1'b1;
               transmit_error_flag_ff <= 1'b0;
            end else if (!in_pkt_ff || link.word != pkt_b_ff) begin
               transmit_error_flag_ff <= 1'b1;
            end
         end
         // Buffer done: its last padding word or its last byte has gone, or word B of a buffer with no words was taken.
         if ((state_ff == TBP_DATA && take && words_ff == 10'h1 && left_ff == 11'h0 &&
              skip_ff == 3'h0) || (state_ff == TBP_BYTES && left_ff == 11'h1 &&
              words_ff == 10'h0) || (state_ff == TBP_CMD_B && take && words_ff == 10'h0)) begin
            buffer_loaded_flag_ff <= cmd_a_ff[IOC_BIT];
            sum_ff <= new_sum;
            if (cmd_a_ff[LAST_BIT]) begin
               in_pkt_ff <= 1'b0;
               status_valid_ff <= 1'b1;
               status_tag_ff <= pkt_b_ff[TAG_HI:TAG_LO];
               // Padding off keeps CRC on regardless.
               status_no_pad_ff <= pkt_b_ff[NOPAD_BIT];
               status_no_crc_ff <= pkt_b_ff[NOCRC_BIT] && !pkt_b_ff[NOPAD_BIT];
               if (err_now) begin
                  transmit_error_flag_ff <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### tbp_host.sv
// Host end: APB slave holding command words, streams A, B, data to the link.
// Assumes software writes A, B, then each data word at the data offset.
`timescale 1ns/10ps
`default_nettype none
module tbp_host (
   input  wire logic         clock,
   input  wire logic         reset,
   tbp_if.host               link,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output var  logic [31:0]  prdata_ff,
   output var  logic         pready_ff,
   output var  logic         pslverr_ff
);
   import tbp_pkg::*;
   logic [31:0] word_ff;
   logic        valid_ff;
   logic        err_seen_ff;
   logic        done_seen_ff;
   logic        err_prev_ff;
   logic        access;
   logic        mapped;

   assign link.word = word_ff;
   assign link.word_valid = valid_ff;
   assign access = psel && penable;
   assign mapped = (paddr == OFS_CMD_A) || (paddr == OFS_CMD_B) ||
                   (paddr == OFS_DATA) || (paddr == OFS_STATUS);

   // Write ready is held off while a previous word still waits on the link; reads are not held off.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= RESET_WORD;
      end else begin
         pready_ff <= access && !pready_ff && !(pwrite && valid_ff);
         pslverr_ff <= access && !pready_ff && !(pwrite && valid_ff) && !mapped;
         prdata_ff <= (paddr == OFS_STATUS) ?
                      {30'h0, done_seen_ff, err_seen_ff} : RESET_WORD;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         word_ff <= RESET_WORD;
         valid_ff <= 1'b0;
      end else begin
         if (valid_ff && link.word_ready) begin
            valid_ff <= 1'b0;
         end
         if (access && pready_ff && pwrite && mapped && paddr != OFS_STATUS) begin
            // Reserved command bits are forced to zero, except word A bits 23:21, which are not in RSVD_A_MASK and pass through.
            case (paddr)
               OFS_CMD_A: word_ff <= pwdata & ~RSVD_A_MASK;
               OFS_CMD_B: word_ff <= pwdata & ~RSVD_B_MASK;
               default:   word_ff <= pwdata;
            endcase
            valid_ff <= 1'b1;
         end
      end
   end

   // Sticky status; a new event wins over the read clear.
   // The error level stays up until the next packet, so only its rise is recorded;
   // otherwise one bad packet would show up again after the read clear.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         err_seen_ff <= 1'b0;
         done_seen_ff <= 1'b0;
         err_prev_ff <= 1'b0;
      end else begin
         err_prev_ff <= link.tx_error;
         if (access && pready_ff && !pwrite && paddr == OFS_STATUS) begin
            err_seen_ff <= 1'b0;
            done_seen_ff <= 1'b0;
         end
         if (link.tx_error && !err_prev_ff) begin
            err_seen_ff <= 1'b1;
         end
         if (link.loaded) begin
            done_seen_ff <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### tbp_monitor.sv
// Concurrent checks on the word link between host writer and command parser.
// Assumes one clock domain; the bench instantiates it beside the link.
`timescale 1ns/10ps
`default_nettype none
module tbp_monitor (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [31:0] word,
   input wire logic        word_valid,
   input wire logic        word_ready,
   input wire logic        tx_error,
   input wire logic        loaded
);
   logic [3:0] idle_ff;
   logic       take;
   assign take = word_valid && word_ready;
   // Counts cycles since the last word was taken, saturating.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         idle_ff <= 4'hF;
      end else if (take) begin
         idle_ff <= 4'h0;
      end else if (idle_ff != 4'hF) begin
         idle_ff <= idle_ff + 4'h1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   chk_word_held: assert property (word_valid && !word_ready |=> word_valid && $stable(word))
      else $error("link word changed before it was taken");
   chk_valid_drop: assert property ($fell(word_valid) |-> $past(word_ready))
      else $error("link valid dropped without a handshake");
   chk_stall_bound: assert property (word_valid && !word_ready |-> ##[1:8] word_ready)
      else $error("link stalled too long");
   chk_loaded_pulse: assert property (loaded |=> !loaded)
      else $error("loaded flag longer than one cycle");
   chk_loaded_cause: assert property (loaded |-> idle_ff < 4'h9)
      else $error("loaded flag without a recent word");
   chk_err_clear: assert property ($fell(tx_error) |-> $past(take) || $past(take, 2))
      else $error("error flag cleared without a word");
   chk_err_stays: assert property ($rose(tx_error) |=> tx_error [*3])
      else $error("error flag did not hold");
   chk_reset_quiet: assert property ($fell(reset) |-> !tx_error && !loaded)
      else $error("flags raised right after reset");
endmodule
`default_nettype wire

// ### test_tx_buffer_command_parser.sv
// Self-checking bench: APB writes to the host end, bytes compared at the parser.
// Assumes the design files and the link monitor are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_tx_buffer_command_parser;
   import tbp_pkg::*;
   logic        clock, reset, psel, penable, pwrite, pready, pslverr, er, st_ok;
   logic [7:0]  paddr, mac_byte;
   logic [31:0] pwdata, prdata, rd;
   logic        mac_valid, mac_sof, mac_eof, st_valid, no_crc, no_pad, tx_err, ld;
   logic [15:0] st_tag, exp_tag;
   logic        exp_crc, exp_pad;
   logic [9:0]  exp_q[$];
   logic [31:0] word_q[$];
   int          mismatches, total_checks, cycles, seed, ld_seen;
   tbp_if tbp_if_inst ();
   tbp_host tbp_host_inst (.clock(clock), .reset(reset), .link(tbp_if_inst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_ff(prdata), .pready_ff(pready), .pslverr_ff(pslverr));
   tbp_parser tbp_parser_inst (.clock(clock), .reset(reset), .link(tbp_if_inst),
      .mac_byte_ff(mac_byte), .mac_valid_ff(mac_valid), .mac_sof_ff(mac_sof),
      .mac_eof_ff(mac_eof), .status_tag_ff(st_tag), .status_no_crc_ff(no_crc),
      .status_no_pad_ff(no_pad), .status_valid_ff(st_valid),
      .transmit_error_flag_ff(tx_err), .buffer_loaded_flag_ff(ld));
   tbp_monitor tbp_monitor_inst (.clock(clock), .reset(reset), .word(tbp_if_inst.word),
      .word_valid(tbp_if_inst.word_valid), .word_ready(tbp_if_inst.word_ready),
      .tx_error(tbp_if_inst.tx_error), .loaded(tbp_if_inst.loaded));
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One buffer: both command words, then offset, payload and end filler words.
   task send_buf(input logic fs, ls, ioc, input logic [1:0] al, input logic [4:0] ofs,
                 input logic [10:0] sz, input logic [31:0] wb);
      logic [31:0] wa, dw;
      int a, n, p;
      wa = {ioc, 5'h00, al, 3'h0, ofs, 2'h0, fs, ls, 1'b0, sz};
      a = (al == ALIGN_16) ? 16 : (al == ALIGN_32) ? 32 : 4;
      n = (ofs + sz + a - 1) / a * a / 4;
      word_q.push_back(wa);
      word_q.push_back(wb);
      apb(1'b1, OFS_CMD_A, wa);
      apb(1'b1, OFS_CMD_B, wb);
      for (int w = 0; w < n; w++) begin
         dw = $random(seed);
         word_q.push_back(dw);
         for (int l = 0; l < 4; l++) begin
            p = w * 4 + l;
            if (p >= ofs && p < ofs + sz) exp_q.push_back({fs && p == ofs, ls && p == ofs + sz - 1, dw[8*l+:8]});
         end
         apb(1'b1, OFS_DATA, dw);
      end
   endtask
   task pkt(input int nb, input int extra, input logic bad_b, input logic [1:0] al, input logic ioc);
      logic [10:0] sz[3];
      logic [31:0] wb;
      int tot;
      tot = 0;
      for (int i = 0; i < nb; i++) begin
         sz[i] = (i > 0 && i < nb - 1) ? 11'd4 : 11'(1 + ($random(seed) & 63));
         tot += sz[i];
      end
      wb = {16'($random(seed)), 2'h0, 2'($random(seed)), 1'b0, 11'(tot + extra)};
      exp_tag = wb[31:16];
      exp_crc = wb[13] && !wb[12];
      exp_pad = wb[12];
      st_ok = !bad_b && extra == 0;
      ld_seen = 0;
      for (int i = 0; i < nb; i++)
         send_buf(i == 0, i == nb - 1, ioc, al, 5'($random(seed)), sz[i],
                  (bad_b && i == nb - 1) ? wb ^ 32'h00010000 : wb);
      for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge clock);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status reg", rd, {30'h0, ioc, bad_b || extra != 0});
      check("loaded pulses", ld_seen, ioc ? nb : 0);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         give_verdict;
      end
      if (mac_valid === 1'b1) check("mac byte", {mac_sof, mac_eof, mac_byte}, exp_q.pop_front());
      if (tbp_if_inst.word_valid === 1'b1 && tbp_if_inst.word_ready === 1'b1)
         check("link word", tbp_if_inst.word, word_q.pop_front());
      if (st_valid === 1'b1 && st_ok) check("status", {st_tag, no_crc, no_pad}, {exp_tag, exp_crc, exp_pad});
      if (st_valid === 1'b1 && st_ok) check("tx error", tx_err, 32'h0);
      if (ld === 1'b1) ld_seen++;
   end
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      seed = 32'h57DF; mismatches = 0; total_checks = 0; cycles = 0; st_ok = 1'b0; ld_seen = 0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      for (int k = 0; k < 8; k++) pkt(1, 0, 1'b0, 2'(k), k[0]);
      for (int k = 0; k < 4; k++) pkt(3, 0, 1'b0, 2'(k), k[1]);
      pkt(2, 1, 1'b0, ALIGN_16, 1'b0);
      pkt(1, 0, 1'b0, ALIGN_4, 1'b1);
      pkt(3, 0, 1'b1, ALIGN_32, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped error", er, 32'h1);
      give_verdict;
   end
endmodule
`default_nettype wire
